/* core/fasf_flags.sv */
// What this block does
// - during write, poll bit returns inverted bit 7 of last programmed byte.
// - after write finishes, poll bit returns stored bit 7.
// - erasing sector reads poll bit 0, becomes 1 on erase completion.
// - suspended erase: poll bit 1 in erasing sector, else stored bit 7.
// - during an algorithm, the targeted address returns status, not array data.
// - activity bit inverts on each read of the commanded bank while write or erase runs.
// - after algorithm ends, activity bit returns stored bit 6.
// - suspended erase: activity bit 1 in erasing sector, else stored bit 6.
// - overtime bit 0 within time limit, 1 once limit exceeded.
// - programming 1 over 0 locks the algorithm until a reset command after overtime shows.
// - erase window bit 0 during erase wait, 1 after it.
// - during sector erase only suspend, or reset once overtime shows, is accepted.
// - suspended erase: window bit 0 in erasing sector, else stored bit 3.
// - window bit 0 in erasing sector while suspended; 0 on failed write, 1 on failed erase.
// - flags at bits 7, 6, 5 and 3; other bits zero.
// - flags only on the commanded bank; other banks read array data.
`timescale 1ns/10ps
`default_nettype none
module fasf_flags
    import fasf_pkg::*;
#(
    parameter int PROG_LIMIT  = PROG_LIMIT_CYC,  // write time limit, cycles
    parameter int ERASE_LIMIT = ERASE_LIMIT_CYC, // erase time limit, cycles
    parameter int EWAIT_LIMIT = ERASE_WAIT_CYC,  // sector erase wait, cycles
    parameter int PROG_CYC    = 400,             // nominal write time
    parameter int ERASE_CYC   = 40_000           // nominal erase time
)
(
    input  wire logic         ref_clk,   // system clock
    input  wire logic         rstn,      // async reset, active low
    input  wire logic         clk_en,    // freezes state when low
    input  wire fasf_cmd_type cmd,       // decoded command pulses
    input  wire logic [7:0]   prog_data, // byte being programmed
    input  wire logic [7:0]   prog_old,  // byte currently stored there
    input  wire fasf_rd_type  rd,        // read strobe and context
    output logic [7:0]        rd_data,   // registered read data
    output logic              busy,      // algorithm running
    output logic              overtime   // time limit exceeded
);

    typedef struct packed
    {
        fasf_mode_type    mode_r;
        logic [CNT_W-1:0] run_cnt_r;
        logic [CNT_W-1:0] wait_cnt_r;
        logic             locked_r;
        logic             overt_r;
        logic [7:0]       last_r;
        logic [7:0]       rd_r;
    } fasf_state_type;

    fasf_state_type st_r;
    fasf_state_type st_nxt;
    logic           tog_bit;
    logic           tog_clear;
    logic           tog_step;
    logic           running;
    logic [7:0]     status;

    localparam logic [CNT_W-1:0] ONE_CNT = {{(CNT_W-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // toggle source
    // ------------------------------------------------------------
    assign running   = (st_r.mode_r == FASF_PROG) ||
                       (st_r.mode_r == FASF_EWAIT) ||
                       (st_r.mode_r == FASF_ERASE) ||
                       (st_r.mode_r == FASF_CERASE);
    // a command ignored mid-algorithm must not restart the toggle
    assign tog_clear = (st_r.mode_r == FASF_IDLE) &&
                       (cmd.start_prog || cmd.start_chip || cmd.sector_cmd);
    assign tog_step  = rd.strobe && rd.own_bank && running;

    fasf_toggle u_toggle
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clk_en  (clk_en),
        .clear   (tog_clear),
        .step    (tog_step),
        .bit_out (tog_bit)
    );

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    always_comb
    begin
        status = UNUSED_BITS;
        case (st_r.mode_r)
            FASF_PROG:
            begin
                status[POLL_POS]   = ~st_r.last_r[POLL_POS];
                status[ACTIV_POS]  = tog_bit;
                status[OVERT_POS]  = st_r.overt_r;
                status[WINDOW_POS] = 1'b0;
            end
            FASF_EWAIT:
            begin
                status[ACTIV_POS]  = tog_bit;
                status[WINDOW_POS] = 1'b0;
            end
            FASF_ERASE, FASF_CERASE:
            begin
                status[POLL_POS]   = 1'b0;
                status[ACTIV_POS]  = tog_bit;
                status[OVERT_POS]  = st_r.overt_r;
                status[WINDOW_POS] = 1'b1;
            end
            FASF_SUSP:
            begin
                // the erasing sector shows 1,1,0,0; others read array
                status[POLL_POS]   = 1'b1;
                status[ACTIV_POS]  = 1'b1;
                status[WINDOW_POS] = 1'b0;
            end
            default:
                status = UNUSED_BITS;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        if (st_r.run_cnt_r != {CNT_W{1'b1}})
            st_nxt.run_cnt_r = st_r.run_cnt_r + ONE_CNT;
        case (st_r.mode_r)
            FASF_IDLE:
            begin
                if (cmd.start_prog)
                begin
                    st_nxt.mode_r    = FASF_PROG;
                    st_nxt.last_r    = prog_data;
                    st_nxt.run_cnt_r = '0;
                    st_nxt.overt_r   = 1'b0;
                    // a 1 cannot be written over a 0
                    st_nxt.locked_r  = |(prog_data & ~prog_old);
                end
                else if (cmd.start_chip)
                begin
                    st_nxt.mode_r    = FASF_CERASE;
                    st_nxt.run_cnt_r = '0;
                    st_nxt.overt_r   = 1'b0;
                    st_nxt.locked_r  = 1'b0;
                end
                else if (cmd.sector_cmd)
                begin
                    st_nxt.mode_r     = FASF_EWAIT;
                    st_nxt.wait_cnt_r = '0;
                    st_nxt.overt_r    = 1'b0;
                    st_nxt.locked_r   = 1'b0;
                end
            end
            FASF_PROG:
            begin
                // all commands ignored, only reset escapes a lock
                if (cmd.reset_cmd && st_r.overt_r)
                begin
                    st_nxt.mode_r  = FASF_IDLE;
                    st_nxt.overt_r = 1'b0;
                end
                else if (!st_r.locked_r &&
                         st_r.run_cnt_r >= CNT_W'(PROG_CYC))
                    st_nxt.mode_r = FASF_IDLE;
                else if (st_r.run_cnt_r >= CNT_W'(PROG_LIMIT))
                    st_nxt.overt_r = 1'b1;
            end
            FASF_EWAIT:
            begin
                if (cmd.sector_cmd)
                    st_nxt.wait_cnt_r = '0;
                else if (st_r.wait_cnt_r >= CNT_W'(EWAIT_LIMIT - 1))
                begin
                    st_nxt.mode_r    = FASF_ERASE;
                    st_nxt.run_cnt_r = '0;
                end
                else
                    st_nxt.wait_cnt_r = st_r.wait_cnt_r + ONE_CNT;
            end
            FASF_ERASE, FASF_CERASE:
            begin
                if (cmd.reset_cmd && st_r.overt_r)
                begin
                    st_nxt.mode_r  = FASF_IDLE;
                    st_nxt.overt_r = 1'b0;
                end
                else if (cmd.suspend && st_r.mode_r == FASF_ERASE)
                begin
                    st_nxt.mode_r = FASF_SUSP;
                end
                else if (st_r.run_cnt_r >= CNT_W'(ERASE_CYC))
                    st_nxt.mode_r = FASF_IDLE;
                else if (st_r.run_cnt_r >= CNT_W'(ERASE_LIMIT))
                    st_nxt.overt_r = 1'b1;
            end
            FASF_SUSP:
            begin
                // counter holds while suspended
                st_nxt.run_cnt_r = st_r.run_cnt_r;
                if (cmd.resume)
                    st_nxt.mode_r = FASF_ERASE;
            end
            default:
                st_nxt.mode_r = FASF_IDLE;
        endcase

        // status only on own bank and relevant address
        if (rd.strobe)
        begin
            if (!rd.own_bank || st_r.mode_r == FASF_IDLE)
                st_nxt.rd_r = rd.array_data;
            else if (st_r.mode_r == FASF_SUSP && !rd.in_erase_sect)
                st_nxt.rd_r = rd.array_data;
            else
                st_nxt.rd_r = status;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            st_r <= '{mode_r: FASF_IDLE, default: '0};
        else if (clk_en)
            st_r <= st_nxt;
    end

    assign rd_data  = st_r.rd_r;
    assign busy     = running;
    assign overtime = st_r.overt_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    prog_poll_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && rd.own_bank && st_r.mode_r == FASF_PROG
        |=> rd_data[POLL_POS] == ~$past(st_r.last_r[POLL_POS]))
        else $error("write poll not inverted");

    erase_poll_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && rd.own_bank && st_r.mode_r == FASF_ERASE
        |=> rd_data[POLL_POS] == 1'b0 && rd_data[WINDOW_POS] == 1'b1)
        else $error("erase status wrong");

    susp_in_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && rd.own_bank && rd.in_erase_sect &&
        st_r.mode_r == FASF_SUSP
        |=> rd_data[7:6] == 2'b11 && rd_data[WINDOW_POS] == 1'b0)
        else $error("suspend status wrong");

    idle_data_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && st_r.mode_r == FASF_IDLE
        |=> rd_data == $past(rd.array_data))
        else $error("idle read not array data");

    other_bank_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && !rd.own_bank
        |=> rd_data == $past(rd.array_data))
        else $error("other bank got status");

    lock_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && st_r.mode_r == FASF_PROG && st_r.locked_r &&
        !cmd.reset_cmd |=> st_r.mode_r == FASF_PROG)
        else $error("locked write completed");

    ewait_win_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && rd.own_bank && st_r.mode_r == FASF_EWAIT
        |=> rd_data[WINDOW_POS] == 1'b0 && rd_data[POLL_POS] == 1'b0)
        else $error("wait window wrong");

    erase_ignore_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && st_r.mode_r == FASF_ERASE && !cmd.suspend &&
        !cmd.reset_cmd && st_r.run_cnt_r < CNT_W'(ERASE_CYC)
        |=> st_r.mode_r == FASF_ERASE)
        else $error("erase left early");

    overt_set_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && st_r.mode_r == FASF_PROG && st_r.locked_r &&
        !cmd.reset_cmd && st_r.run_cnt_r >= CNT_W'(PROG_LIMIT)
        |=> st_r.overt_r)
        else $error("overtime not raised");

    unused_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && rd.own_bank && running
        |=> rd_data[4] == 1'b0 && rd_data[2:0] == 3'b000)
        else $error("unused status bits set");

    reset_clr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && cmd.reset_cmd && st_r.overt_r && running
        |=> st_r.mode_r == FASF_IDLE && !st_r.overt_r)
        else $error("reset command ignored");

    chip_poll_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && rd.strobe && rd.own_bank && st_r.mode_r == FASF_CERASE
        |=> rd_data[POLL_POS] == 1'b0 && rd_data[WINDOW_POS] == 1'b1)
        else $error("chip erase status wrong");

    tog_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && tog_clear |=> tog_bit == 1'b0)
        else $error("toggle not cleared at start");

endmodule
`default_nettype wire

/* inc/fasf_pkg.sv */
package fasf_pkg;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int POLL_POS    = 7;
    localparam int ACTIV_POS   = 6;
    localparam int OVERT_POS   = 5;
    localparam int WINDOW_POS  = 3;
    localparam logic [7:0] UNUSED_BITS = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int ERASE_WAIT_US   = 50;
    localparam int ERASE_WAIT_CYC  =
        (ERASE_WAIT_US * (CLK_HZ / 1_000_000));
    localparam int PROG_LIMIT_CYC  = 100_000;
    localparam int ERASE_LIMIT_CYC = 2_000_000;
    localparam int CNT_W           = 24;

    // ------------------------------------------------------------
    // algorithm states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        FASF_IDLE    = 3'b000,
        FASF_PROG    = 3'b001,
        FASF_EWAIT   = 3'b010,
        FASF_ERASE   = 3'b011,
        FASF_SUSP    = 3'b100,
        FASF_CERASE  = 3'b101
    } fasf_mode_type;

    typedef struct packed
    {
        logic       start_prog;
        logic       start_chip;
        logic       sector_cmd;
        logic       suspend;
        logic       resume;
        logic       reset_cmd;
    } fasf_cmd_type;

    typedef struct packed
    {
        logic       strobe;
        logic       own_bank;
        logic       in_erase_sect;
        logic [7:0] array_data;
    } fasf_rd_type;

endpackage

/* core/fasf_toggle.sv */
`timescale 1ns/10ps
`default_nettype none
module fasf_toggle
    import fasf_pkg::*;
(
    input  wire logic ref_clk,  // system clock
    input  wire logic rstn,     // async reset, active low
    input  wire logic clk_en,   // freezes state when low
    input  wire logic clear,    // new algorithm starts
    input  wire logic step,     // qualifying read strobe
    output logic      bit_out   // toggle flip-flop
);

    typedef struct packed
    {
        logic tog_r;
    } fasf_tog_type;

    fasf_tog_type st_r;
    fasf_tog_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (clear)
            st_nxt.tog_r = 1'b0;
        else if (step)
            st_nxt.tog_r = ~st_r.tog_r;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            st_r <= '0;
        else if (clk_en)
            st_r <= st_nxt;
    end

    assign bit_out = st_r.tog_r;

    toggle_step_a: assert property (@(posedge ref_clk) disable iff (!rstn)
        clk_en && step && !clear |=> bit_out != $past(bit_out))
        else $error("toggle did not invert");

endmodule
`default_nettype wire

/* test/fasf_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fasf_cpu_model
    import fasf_pkg::*;
(
    input  wire logic       ref_clk,   // system clock
    input  wire logic [7:0] rd_data,   // read result from the flash
    output fasf_cmd_type    cmd,       // decoded command pulses
    output logic [7:0]      prog_data, // byte being programmed
    output logic [7:0]      prog_old,  // byte stored at that address
    output fasf_rd_type     rd,        // read strobe and context
    output logic            clk_en     // clock enable
);
    // ------------------------------------------------------------
    // bus side of the cpu
    // ------------------------------------------------------------
    initial
    begin
        cmd       = '0;
        prog_data = 8'h00;
        prog_old  = 8'hFF;
        rd        = '0;
        clk_en    = 1'b1;
    end

    // the reset command is only sent by the bench once overtime shows
    task automatic send(input fasf_cmd_type c, input logic [7:0] d,
                        input logic [7:0] o);
        @(posedge ref_clk);
        cmd       <= c;
        prog_data <= d;
        prog_old  <= o;
        @(posedge ref_clk);
        cmd       <= '0;
        prog_data <= ~d;
        prog_old  <= ~o;
    endtask

    // array data is inverted once the strobe drops so stale values
    // cannot pass for fresh ones
    task automatic read(input logic own, input logic ins,
                        input logic [7:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        rd <= {1'b1, own, ins, a};
        @(posedge ref_clk);
        rd <= {1'b0, own, ins, ~a};
        #1;
        q = rd_data;
    endtask

    // clock enable is held low for n cycles, so all flash state freezes
    task automatic freeze(input int n);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (n) @(posedge ref_clk);
        clk_en <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* test/fasf_flags_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module fasf_flags_tb;
    import fasf_pkg::*;
    localparam logic [5:0] C_PROG = 6'h20;
    localparam logic [5:0] C_CHIP = 6'h10;
    localparam logic [5:0] C_SECT = 6'h08;
    localparam logic [5:0] C_SUSP = 6'h04;
    localparam logic [5:0] C_RES  = 6'h02;
    localparam logic [5:0] C_RST  = 6'h01;
    logic         ref_clk = 1'b0;
    logic         rstn    = 1'b0;
    fasf_cmd_type cmd;
    fasf_rd_type  rd;
    logic [7:0]   prog_data;
    logic [7:0]   prog_old;
    logic [7:0]   rd_data;
    logic [7:0]   q;
    logic [7:0]   a;
    logic         busy;
    logic         overtime;
    logic         clk_en;
    int           bad_count = 0;
    int           n_checks  = 0;
    int           exp_tog;

    always #10 ref_clk = ~ref_clk;

    fasf_cpu_model i_fasf_cpu_model (.ref_clk(ref_clk), .rd_data(rd_data),
        .cmd(cmd), .prog_data(prog_data), .prog_old(prog_old), .rd(rd),
        .clk_en(clk_en));

    fasf_flags #(.PROG_LIMIT(50), .EWAIT_LIMIT(8), .PROG_CYC(10),
        .ERASE_CYC(40)) i_fasf_flags (.ref_clk(ref_clk),
        .rstn(rstn), .clk_en(clk_en), .cmd(cmd), .prog_data(prog_data),
        .prog_old(prog_old), .rd(rd), .rd_data(rd_data), .busy(busy),
        .overtime(overtime));

    // ------------------------------------------------------------
    // compare and access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, exp, msk);
        n_checks++;
        if ((got & msk) !== (exp & msk))
        begin
            bad_count++;
            $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // status read of the commanded bank; the model toggle flips each time
    task automatic sread(input logic ins, p, o, w, input logic [7:0] m);
        a = 8'($urandom);
        i_fasf_cpu_model.read(1'b1, ins, a, q);
        chk(q, {p, exp_tog[0], o, 1'b0, w, 3'b000}, m);
        exp_tog ^= 1;
    endtask

    task automatic aread(input logic own, ins);
        a = 8'($urandom);
        i_fasf_cpu_model.read(own, ins, a, q);
        chk(q, a, 8'hFF);
    endtask

    task automatic wait_sig(input logic sel, v, input int lim);
        int i;
        i = 0;
        while ((sel ? overtime : busy) !== v && i < lim)
        begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        chk_bit(sel ? overtime : busy, v);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        a = 8'($urandom(55));
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        exp_tog = 0;
        i_fasf_cpu_model.send(C_PROG, 8'h5A, 8'hFF);
        sread(1'b0, 1'b1, 1'b0, 1'b0, 8'hFF);
        sread(1'b0, 1'b1, 1'b0, 1'b0, 8'hFF);
        aread(1'b0, 1'b0);
        i_fasf_cpu_model.freeze(20);
        chk_bit(busy, 1'b1);
        wait_sig(1'b0, 1'b0, 40);
        aread(1'b1, 1'b0);
        chk_bit(overtime, 1'b0);
        $display("test program done");
        exp_tog = 0;
        i_fasf_cpu_model.send(C_PROG, 8'h81, 8'h00);
        sread(1'b0, 1'b0, 1'b0, 1'b0, 8'hFF);
        wait_sig(1'b1, 1'b1, 100);
        chk_bit(busy, 1'b1);
        sread(1'b0, 1'b0, 1'b1, 1'b0, 8'hFF);
        sread(1'b0, 1'b0, 1'b1, 1'b0, 8'hFF);
        i_fasf_cpu_model.send(C_RST, 8'h00, 8'hFF);
        wait_sig(1'b0, 1'b0, 20);
        chk_bit(overtime, 1'b0);
        aread(1'b1, 1'b0);
        $display("test lock done");
        exp_tog = 0;
        i_fasf_cpu_model.send(C_SECT, 8'h00, 8'hFF);
        sread(1'b1, 1'b0, 1'b0, 1'b0, 8'hFF);
        i_fasf_cpu_model.send(C_SECT, 8'h00, 8'hFF);
        repeat (4) @(posedge ref_clk);
        sread(1'b1, 1'b0, 1'b0, 1'b0, 8'hFF);
        repeat (4) @(posedge ref_clk);
        sread(1'b1, 1'b0, 1'b0, 1'b1, 8'hFF);
        i_fasf_cpu_model.send(C_PROG, 8'h00, 8'hFF);
        sread(1'b1, 1'b0, 1'b0, 1'b1, 8'hFF);
        i_fasf_cpu_model.send(C_SUSP, 8'h00, 8'hFF);
        exp_tog = 1;
        sread(1'b1, 1'b1, 1'b0, 1'b0, 8'hF7);
        exp_tog = 1;
        sread(1'b1, 1'b1, 1'b0, 1'b0, 8'hF7);
        aread(1'b1, 1'b0);
        i_fasf_cpu_model.send(C_RES, 8'h00, 8'hFF);
        sread(1'b1, 1'b0, 1'b0, 1'b1, 8'hBF);
        wait_sig(1'b0, 1'b0, 200);
        aread(1'b1, 1'b1);
        $display("test sector erase done");
        exp_tog = 0;
        i_fasf_cpu_model.send(C_CHIP, 8'h00, 8'hFF);
        sread(1'b1, 1'b0, 1'b0, 1'b1, 8'hFF);
        sread(1'b1, 1'b0, 1'b0, 1'b1, 8'hFF);
        wait_sig(1'b0, 1'b0, 200);
        aread(1'b1, 1'b1);
        $display("test chip erase done");
        test_done;
    end

    // the tests need well under a thousand cycles; this allows five
    initial
    begin
        #100_000;
        bad_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done;
    end
endmodule
`default_nettype wire
